/* src/lic_pkg.sv */
// Constants for the local interrupt controller state and identity block
package lic_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_BASE_LO = 8'h00;
   localparam logic [7:0] OFF_BASE_HI = 8'h04;
   localparam logic [7:0] OFF_ID = 8'h08;
   localparam logic [7:0] OFF_ARBITRATION_IDENTIFIER = 8'h0c;
   localparam logic [7:0] OFF_PROC_ID = 8'h10;
   localparam logic [7:0] OFF_SVR = 8'h14;
   localparam logic [7:0] OFF_DFR = 8'h18;
   localparam logic [7:0] OFF_LDR = 8'h1c;
   localparam logic [7:0] OFF_TPR = 8'h20;
   localparam logic [7:0] OFF_CMD_LO = 8'h24;
   localparam logic [7:0] OFF_CMD_HI = 8'h28;
   localparam logic [7:0] OFF_TMR_INIT = 8'h2c;
   localparam logic [7:0] OFF_TMR_CUR = 8'h30;
   localparam logic [7:0] OFF_DCR = 8'h34;
   localparam logic [7:0] OFF_VERSION = 8'h38;
   localparam logic [7:0] OFF_LVT0 = 8'h40;
   localparam logic [7:0] OFF_ISR0 = 8'h80;
   localparam logic [7:0] OFF_TRIG0 = 8'ha0;
   localparam logic [7:0] OFF_IRR0 = 8'hc0;
   localparam int LVT_N = 6;
   localparam int BOOT_BIT = 8;
   localparam int GEN_BIT = 11;
   localparam int BASE_LSB = 12;
   localparam int SWEN_BIT = 8;
   localparam int LVT_MASK_BIT = 16;
   localparam int ID_LSB = 24;
   localparam logic [23:0] BASE_RST = 24'h0fee00;
   localparam logic [8:0] SVR_RST = 9'h0ff;
   localparam logic [3:0] DFR_RST = 4'hf;
   localparam logic [31:0] LVT_RST = 32'h0001_0000;
   localparam logic [7:0] ID_MASK_BUS = 8'h0f;
   localparam logic [7:0] ID_MASK_EXT = 8'hff;
   // Arbitrary value, identifies nothing
   localparam logic [31:0] VERSION_VAL = 32'h0005_0010;
   typedef enum logic [2:0] {
      LIC_MSG_FIXED, LIC_MSG_NMI, LIC_MSG_SMI, LIC_MSG_INIT,
      LIC_MSG_STARTUP, LIC_MSG_INIT_DEASSERT
   } lic_msg_t;
endpackage : lic_pkg

/* src/lic_core.sv */
// Base locator, identity and reset-state control of a local interrupt unit
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module lic_core #(
   parameter bit BUS_VARIANT = 1'b0
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [lic_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic bootStrap,
   input wire logic [7:0] identifierStrap,
   input wire logic msgValid,
   input wire lic_pkg::lic_msg_t msgType,
   input wire logic [7:0] msgVector,
   input wire logic msgLevel,
   input wire logic ipiBusy,
   input wire logic initPin,
   input wire logic stopClockPin,
   input wire logic [35:0] memAddr,
   output logic memHit,
   output logic nmiReq,
   output logic smiReq,
   output logic initReq,
   output logic startupReq,
   output logic [7:0] startupVector,
   output logic stopClockReq,
   output logic ipiSendReq,
   output logic waitStartup,
   output logic swDisabled
);
   import lic_pkg::*;

   typedef struct packed {
      logic [23:0] base;
      logic globalEn;
      logic bootFlag;
      logic [7:0] idReg;
      logic [7:0] arbId;
      logic [7:0] initId;
      logic [8:0] svr;
      logic [3:0] destination_format_register;
      logic [31:0] logical_destination_register;
      logic [31:0] task_priority_register;
      logic [31:0] cmdLo;
      logic [31:0] cmdHi;
      logic [31:0] tmrInit;
      logic [31:0] tmrCur;
      logic [31:0] dcr;
      logic [LVT_N-1:0][31:0] local_vector_table;
      logic [255:0] request_vector;
      logic [255:0] in_service_vector;
      logic [255:0] trig;
      logic disPend;
      logic swDis;
      logic waitSu;
      logic capPend;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic memHit;
      logic nmi;
      logic smi;
      logic init;
      logic su;
      logic [7:0] suVec;
      logic stopClk;
      logic ipiSend;
   } lic_state_t;

   lic_state_t st_r;
   lic_state_t st_nxt;

   function automatic logic [7:0] idMask(input logic bus);
      return bus ? ID_MASK_BUS : ID_MASK_EXT;
   endfunction : idMask

   function automatic logic [31:0] vecWord(input logic [255:0] v,
                                           input logic [2:0] idx);
      return v[{idx, 5'h00} +: 32];
   endfunction : vecWord

   // Registers cleared by power-up, hard reset and init alike
   function automatic lic_state_t clearShared(input lic_state_t s);
      lic_state_t r;
      r = s;
      r.request_vector = '0;
      r.in_service_vector = '0;
      r.trig = '0;
      r.cmdLo = '0;
      r.cmdHi = '0;
      r.logical_destination_register = '0;
      r.task_priority_register = '0;
      r.tmrInit = '0;
      r.tmrCur = '0;
      r.dcr = '0;
      r.destination_format_register = DFR_RST;
      for (int i = 0; i < LVT_N; i++) begin
         r.local_vector_table[i] = LVT_RST;
      end
      r.svr = SVR_RST;
      r.disPend = 1'b0;
      r.swDis = 1'b0;
      return r;
   endfunction : clearShared

   logic access;
   logic done;
   logic [7:0] off;
   logic mapped;
   logic [31:0] rdVal;
   logic msgOk;

   assign access = psel && penable && !st_r.pready;
   assign done = psel && penable && st_r.pready;
   assign off = paddr;
   // Global disable makes the controller deaf to the message bus
   assign msgOk = msgValid && st_r.globalEn;

   always_comb begin
      mapped = 1'b1;
      rdVal = '0;
      case (off)
         OFF_BASE_LO: rdVal = {st_r.base[19:0], st_r.globalEn, 2'b00,
                               st_r.bootFlag, 8'h00};
         OFF_BASE_HI: rdVal = {28'h0, st_r.base[23:20]};
         OFF_ID: rdVal = {st_r.idReg, 24'h0};
         OFF_ARBITRATION_IDENTIFIER: rdVal = {st_r.arbId, 24'h0};
         OFF_PROC_ID: rdVal = {st_r.initId, 24'h0};
         OFF_SVR: rdVal = {23'h0, st_r.svr};
         OFF_DFR: rdVal = {st_r.destination_format_register, 28'hfffffff};
         OFF_LDR: rdVal = st_r.logical_destination_register;
         OFF_TPR: rdVal = st_r.task_priority_register;
         OFF_CMD_LO: rdVal = st_r.cmdLo;
         OFF_CMD_HI: rdVal = st_r.cmdHi;
         OFF_TMR_INIT: rdVal = st_r.tmrInit;
         OFF_TMR_CUR: rdVal = st_r.tmrCur;
         OFF_DCR: rdVal = st_r.dcr;
         OFF_VERSION: rdVal = VERSION_VAL;
         default: begin
            if (off >= OFF_LVT0 && off < OFF_LVT0 + 8'(4 * LVT_N)) begin
               rdVal = st_r.local_vector_table[3'((off - OFF_LVT0) >> 2)];
            end else if (off >= OFF_ISR0 && off < OFF_TRIG0) begin
               rdVal = vecWord(st_r.in_service_vector, off[4:2]);
            end else if (off >= OFF_TRIG0 && off < OFF_IRR0) begin
               rdVal = vecWord(st_r.trig, off[4:2]);
            end else if (off >= OFF_IRR0 && off < OFF_IRR0 + 8'h20) begin
               rdVal = vecWord(st_r.request_vector, off[4:2]);
            end else begin
               mapped = 1'b0;
            end
         end
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.nmi = 1'b0;
      st_nxt.smi = 1'b0;
      st_nxt.init = 1'b0;
      st_nxt.su = 1'b0;
      st_nxt.ipiSend = 1'b0;
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
      // Straps are caught on the first edge after reset release
      if (st_r.capPend) begin
         st_nxt.capPend = 1'b0;
         st_nxt.bootFlag = bootStrap;
         st_nxt.idReg = identifierStrap & idMask(BUS_VARIANT);
         st_nxt.initId = identifierStrap & idMask(BUS_VARIANT);
         st_nxt.arbId = identifierStrap & idMask(BUS_VARIANT);
      end
      // Window base is the base field above twelve zero bits
      st_nxt.memHit = st_r.globalEn &&
                      memAddr[35:BASE_LSB] == st_r.base;
      if (access) begin
         st_nxt.pready = 1'b1;
         st_nxt.pslverr = !mapped;
         st_nxt.prdata = pwrite ? 32'h0 : rdVal;
      end
      if (done && pwrite && mapped) begin
         case (off)
            OFF_BASE_LO: begin
               st_nxt.base[19:0] = pwdata[31:BASE_LSB];
               st_nxt.globalEn = pwdata[GEN_BIT];
            end
            OFF_BASE_HI: st_nxt.base[23:20] = pwdata[3:0];
            OFF_ID: st_nxt.idReg = pwdata[31:ID_LSB] & idMask(BUS_VARIANT);
            OFF_SVR: begin
               st_nxt.svr = pwdata[8:0];
               if (!pwdata[SWEN_BIT]) begin
                  st_nxt.disPend = !st_r.swDis;
               end else begin
                  st_nxt.disPend = 1'b0;
                  st_nxt.swDis = 1'b0;
               end
            end
            OFF_DFR: st_nxt.destination_format_register = pwdata[31:28];
            OFF_LDR: st_nxt.logical_destination_register = pwdata;
            OFF_TPR: st_nxt.task_priority_register = pwdata;
            OFF_CMD_LO: begin
               st_nxt.cmdLo = pwdata;
               st_nxt.ipiSend = 1'b1;
            end
            OFF_CMD_HI: st_nxt.cmdHi = pwdata;
            OFF_TMR_INIT: st_nxt.tmrInit = pwdata;
            OFF_DCR: st_nxt.dcr = pwdata;
            default: begin
               if (off >= OFF_LVT0 && off < OFF_LVT0 + 8'(4 * LVT_N)) begin
                  st_nxt.local_vector_table[3'((off - OFF_LVT0) >> 2)] = pwdata;
                  if (st_r.swDis || st_r.disPend) begin
                     st_nxt.local_vector_table[3'((off - OFF_LVT0) >> 2)][LVT_MASK_BIT] =
                        1'b1;
                  end
               end
            end
         endcase
      end
      // A transfer in flight finishes before the disable takes hold
      if (st_r.disPend && !ipiBusy) begin
         st_nxt.disPend = 1'b0;
         st_nxt.swDis = 1'b1;
      end
      if (st_nxt.swDis) begin
         for (int i = 0; i < LVT_N; i++) begin
            st_nxt.local_vector_table[i][LVT_MASK_BIT] = 1'b1;
         end
      end
      // Messages are answered whether or not software disabled us
      st_nxt.stopClk = stopClockPin &&
                       (st_r.bootFlag || !BUS_VARIANT);
      if (msgOk) begin
         case (msgType)
            LIC_MSG_FIXED: begin
               // Pending bits stay put while software-disabled
               st_nxt.request_vector[msgVector] = 1'b1;
               st_nxt.trig[msgVector] = msgLevel;
            end
            LIC_MSG_NMI: st_nxt.nmi = 1'b1;
            LIC_MSG_SMI: st_nxt.smi = 1'b1;
            LIC_MSG_STARTUP: begin
               if (!st_r.bootFlag && st_r.waitSu) begin
                  st_nxt.su = 1'b1;
                  st_nxt.suVec = msgVector;
                  st_nxt.waitSu = 1'b0;
               end
            end
            LIC_MSG_INIT_DEASSERT: begin
               if (BUS_VARIANT) begin
                  st_nxt.arbId = st_r.idReg;
               end
            end
            default: ;
         endcase
      end
      // Init keeps identifiers and base locator, then waits for startup
      if (initPin || (msgOk && msgType == LIC_MSG_INIT)) begin
         st_nxt = clearShared(st_nxt);
         st_nxt.init = 1'b1;
         st_nxt.waitSu = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_r <= clearShared('0);
         st_r.base <= BASE_RST;
         st_r.globalEn <= 1'b1;
         st_r.capPend <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign memHit = st_r.memHit;
   assign nmiReq = st_r.nmi;
   assign smiReq = st_r.smi;
   assign initReq = st_r.init;
   assign startupReq = st_r.su;
   assign startupVector = st_r.suVec;
   assign stopClockReq = st_r.stopClk;
   assign ipiSendReq = st_r.ipiSend;
   assign waitStartup = st_r.waitSu;
   assign swDisabled = st_r.swDis;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   property p_boot_capture;
      $fell(st_r.capPend) |-> st_r.bootFlag == $past(bootStrap);
   endproperty
   a_boot_capture: assert property (p_boot_capture)
      else $error("boot flag not taken from strap");

   property p_id_capture;
      $fell(st_r.capPend) |-> st_r.initId == st_r.idReg &&
         st_r.idReg == ($past(identifierStrap) & idMask(BUS_VARIANT));
   endproperty
   a_id_capture: assert property (p_id_capture)
      else $error("identifier strap not captured");

   property p_init_id_kept;
      !st_r.capPend && !$past(st_r.capPend) |-> $stable(st_r.initId);
   endproperty
   a_init_id_kept: assert property (p_init_id_kept)
      else $error("initial identifier changed");

   property p_base_after_reset;
      $fell(reset) |-> st_r.base == BASE_RST && st_r.svr == SVR_RST
         && st_r.destination_format_register == DFR_RST;
   endproperty
   a_base_after_reset: assert property (p_base_after_reset)
      else $error("reset values wrong");

   property p_window_hit;
      st_r.globalEn && memAddr == {st_r.base, 12'h000}
         && $stable(st_r.base) ##1 $stable(st_r.base) |-> memHit;
   endproperty
   a_window_hit: assert property (p_window_hit)
      else $error("window base not decoded");

   property p_disabled_masked;
      swDisabled |-> st_r.local_vector_table[0][LVT_MASK_BIT] &&
         st_r.local_vector_table[LVT_N-1][LVT_MASK_BIT];
   endproperty
   a_disabled_masked: assert property (p_disabled_masked)
      else $error("vector table mask clear while disabled");

   property p_disable_waits;
      st_r.disPend && ipiBusy |=> !swDisabled;
   endproperty
   a_disable_waits: assert property (p_disable_waits)
      else $error("disabled during busy transfer");

   property p_disable_explicit;
      $rose(swDisabled) |-> $past(st_r.disPend);
   endproperty
   a_disable_explicit: assert property (p_disable_explicit)
      else $error("disabled without explicit clear");

   property p_irr_held;
      swDisabled && !initPin && !(msgOk && msgType == LIC_MSG_INIT)
         |=> (st_r.request_vector & $past(st_r.request_vector)) == $past(st_r.request_vector);
   endproperty
   a_irr_held: assert property (p_irr_held)
      else $error("pending request lost while disabled");

   property p_nmi_answer;
      msgOk && msgType == LIC_MSG_NMI |=> nmiReq;
   endproperty
   a_nmi_answer: assert property (p_nmi_answer)
      else $error("NMI message not answered");

   property p_init_keeps_id;
      initPin ##1 !$past(st_r.capPend) |-> $stable(st_r.idReg)
         && waitStartup;
   endproperty
   a_init_keeps_id: assert property (p_init_keeps_id)
      else $error("init disturbed identifier");

   property p_deassert_arb;
      msgOk && msgType == LIC_MSG_INIT_DEASSERT && BUS_VARIANT
         && !initPin |=> st_r.arbId == $past(st_r.idReg);
   endproperty
   a_deassert_arb: assert property (p_deassert_arb)
      else $error("arbitration identifier not reloaded");
endmodule : lic_core

/* dv/lic_msg_model.sv */
// Core-side pins and message bus model driving the controller
`timescale 1ns/1ps
module lic_msg_model (
   input wire logic sys_clk,
   output logic msgValid,
   output lic_pkg::lic_msg_t msgType,
   output logic [7:0] msgVector,
   output logic msgLevel,
   output logic ipiBusy,
   output logic initPin,
   output logic stopClockPin
);
   import lic_pkg::*;
   initial begin
      msgValid = 1'b0;
      msgType = LIC_MSG_FIXED;
      msgVector = 8'h00;
      msgLevel = 1'b0;
      ipiBusy = 1'b0;
      initPin = 1'b0;
      stopClockPin = 1'b0;
   end
   // Vector and level turn to inverted junk after the strobe, so a stale sample shows
   task automatic send(input lic_msg_t t, input logic [7:0] v,
         input logic l);
      @(posedge sys_clk);
      msgValid <= 1'b1;
      msgType <= t;
      msgVector <= v;
      msgLevel <= l;
      @(posedge sys_clk);
      msgValid <= 1'b0;
      msgVector <= ~v;
      msgLevel <= ~l;
   endtask : send
   task automatic pins(input logic b, input logic i, input logic s);
      @(posedge sys_clk);
      ipiBusy <= b;
      initPin <= i;
      stopClockPin <= s;
   endtask : pins
endmodule : lic_msg_model

/* dv/test_local_intc_base_id_state.sv */
// Self-checking bench for the controller base, identity and state block
`timescale 1ns/1ps
module test_local_intc_base_id_state;
   import lic_pkg::*;
   localparam logic [7:0] RA [20] = '{OFF_BASE_LO, OFF_BASE_HI, OFF_ID,
      OFF_ARBITRATION_IDENTIFIER, OFF_PROC_ID, OFF_SVR, OFF_DFR, OFF_LDR, OFF_TPR,
      OFF_CMD_LO, OFF_CMD_HI, OFF_TMR_INIT, OFF_TMR_CUR, OFF_DCR,
      OFF_VERSION, OFF_LVT0, 8'h54, OFF_ISR0, OFF_TRIG0, OFF_IRR0};
   localparam logic [31:0] RV [20] = '{32'hfee00800, 32'h0, 32'h5a000000,
      32'h5a000000, 32'h5a000000, 32'hff, 32'hffffffff, 32'h0, 32'h0,
      32'h0, 32'h0, 32'h0, 32'h0, 32'h0, VERSION_VAL, LVT_RST, LVT_RST,
      32'h0, 32'h0, 32'h0};
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic bootStrap = 1'b1;
   logic [7:0] identifierStrap = 8'h5a;
   logic [35:0] memAddr = 36'h0;
   logic [31:0] prdata, rd, ev, prdataB, rdB;
   logic pready, pslverr, err, memHit, nmiReq, smiReq, initReq, startupReq;
   logic stopClockReq, ipiSendReq, waitStartup, swDisabled, msgValid;
   logic msgLevel, ipiBusy, initPin, stopClockPin, stopClockReqB;
   logic [7:0] msgVector, startupVector;
   lic_msg_t msgType;
   int failures = 0;
   int nCompared = 0;
   int n;

   always #2.5 sys_clk = ~sys_clk;

   lic_core #(.BUS_VARIANT(1'b0)) lic_core_i (.sys_clk, .reset, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .bootStrap, .identifierStrap, .msgValid, .msgType, .msgVector,
      .msgLevel, .ipiBusy, .initPin, .stopClockPin, .memAddr, .memHit,
      .nmiReq, .smiReq, .initReq, .startupReq, .startupVector, .stopClockReq,
      .ipiSendReq, .waitStartup, .swDisabled);
   lic_msg_model lic_msg_model_i (.sys_clk, .msgValid, .msgType, .msgVector,
      .msgLevel, .ipiBusy, .initPin, .stopClockPin);
   // Bus-based variant shares every input, so its answers line up in time
   if (1'b1) begin : g_bus
      lic_core #(.BUS_VARIANT(1'b1)) lic_core_i (.sys_clk, .reset, .psel,
         .penable, .pwrite, .paddr, .pwdata, .prdata(prdataB), .pready(),
         .pslverr(), .bootStrap, .identifierStrap, .msgValid, .msgType,
         .msgVector, .msgLevel, .ipiBusy, .initPin, .stopClockPin, .memAddr,
         .memHit(), .nmiReq(), .smiReq(), .initReq(), .startupReq(),
         .startupVector(), .stopClockReq(stopClockReqB), .ipiSendReq(),
         .waitStartup(), .swDisabled());
   end

   task automatic end_sim;
      if (failures == 0 && nCompared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nCompared++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One wait state is expected, but the bound only guards against a hang
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int k;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (pready !== 1'b1) begin
         failures++;
         end_sim();
      end
      rd = prdata;
      rdB = prdataB;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdchk
   task automatic restart(input logic b);
      @(posedge sys_clk);
      reset <= 1'b1;
      bootStrap <= b;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      for (int i = 0; i < 20; i++) begin
         ev = RV[i];
         if (i == 0) ev[BOOT_BIT] = b;
         rdchk(RA[i], ev);
      end
      chk(swDisabled, 1'b0);
   endtask : restart
   task automatic hit(input logic [35:0] a, input logic e);
      @(posedge sys_clk);
      memAddr <= a;
      @(posedge sys_clk);
      #1 chk(memHit, e);
   endtask : hit
   task automatic msg(input lic_msg_t t, input logic [7:0] v, input logic l);
      lic_msg_model_i.send(t, v, l);
      #1;
   endtask : msg

   initial begin
      restart(1'b1);
      rdchk(OFF_ARBITRATION_IDENTIFIER, 32'h5a000000);
      chk(rdB, 32'h0a000000);
      apb(1'b1, 8'h3c, 32'hffffffff);
      chk(err, 1'b1);
      hit(36'h0_fee0_0abc, 1'b1);
      hit(36'h0_fee0_1000, 1'b0);
      apb(1'b1, OFF_BASE_LO, 32'h12345eff);
      apb(1'b1, OFF_BASE_HI, 32'hfffffff3);
      rdchk(OFF_BASE_LO, 32'h12345900);
      rdchk(OFF_BASE_HI, 32'h00000003);
      hit(36'h3_1234_5ffc, 1'b1);
      hit(36'h0_fee0_0000, 1'b0);
      apb(1'b1, OFF_BASE_LO, 32'h12345000);
      hit(36'h3_1234_5000, 1'b0);
      msg(LIC_MSG_NMI, 8'h00, 1'b0);
      chk(nmiReq, 1'b0);
      apb(1'b1, OFF_BASE_LO, 32'h12345800);
      hit(36'h3_1234_5000, 1'b1);
      apb(1'b1, OFF_ID, 32'ha7000000);
      rdchk(OFF_ID, 32'ha7000000);
      chk(rdB, 32'h07000000);
      rdchk(OFF_PROC_ID, 32'h5a000000);
      chk(rdB, 32'h0a000000);
      msg(LIC_MSG_INIT_DEASSERT, 8'h00, 1'b0);
      rdchk(OFF_ARBITRATION_IDENTIFIER, 32'h5a000000);
      chk(rdB, 32'h07000000);
      msg(LIC_MSG_NMI, 8'h00, 1'b0);
      chk(nmiReq, 1'b1);
      @(posedge sys_clk);
      #1 chk(nmiReq, 1'b0);
      msg(LIC_MSG_FIXED, 8'h45, 1'b1);
      lic_msg_model_i.pins(1'b0, 1'b0, 1'b1);
      lic_msg_model_i.pins(1'b0, 1'b0, 1'b0);
      #1 chk(stopClockReq, 1'b1);
      chk(stopClockReqB, 1'b1);
      // Disable is requested while a message is in flight
      apb(1'b1, OFF_LVT0 + 8'h04, 32'h00000031);
      lic_msg_model_i.pins(1'b1, 1'b0, 1'b0);
      apb(1'b1, OFF_SVR, 32'h000000ff);
      repeat (3) @(posedge sys_clk);
      #1 chk(swDisabled, 1'b0);
      lic_msg_model_i.pins(1'b0, 1'b0, 1'b0);
      for (n = 0; n < 8 && swDisabled !== 1'b1; n++) begin
         @(posedge sys_clk);
      end
      #1 chk(swDisabled, 1'b1);
      rdchk(OFF_LVT0 + 8'h04, 32'h00010031);
      apb(1'b1, OFF_LVT0, 32'h00000030);
      rdchk(OFF_LVT0, 32'h00010030);
      rdchk(OFF_IRR0 + 8'h08, 32'h00000020);
      msg(LIC_MSG_SMI, 8'h00, 1'b0);
      chk(smiReq, 1'b1);
      msg(LIC_MSG_NMI, 8'h00, 1'b0);
      chk(nmiReq, 1'b1);
      apb(1'b1, OFF_CMD_LO, 32'h000004aa);
      #1;
      for (n = 0; n < 4 && ipiSendReq !== 1'b1; n++) begin
         @(posedge sys_clk);
         #1;
      end
      chk(ipiSendReq, 1'b1);
      apb(1'b1, OFF_SVR, 32'h000001ff);
      @(posedge sys_clk);
      #1 chk(swDisabled, 1'b0);
      apb(1'b1, OFF_LVT0, 32'h00000030);
      rdchk(OFF_LVT0, 32'h00000030);
      apb(1'b1, OFF_LDR, 32'h11000000);
      lic_msg_model_i.pins(1'b0, 1'b1, 1'b0);
      lic_msg_model_i.pins(1'b0, 1'b0, 1'b0);
      #1 chk(initReq, 1'b1);
      chk(waitStartup, 1'b1);
      msg(LIC_MSG_STARTUP, 8'h9a, 1'b0);
      chk(startupReq, 1'b0);
      rdchk(OFF_LDR, 32'h0);
      rdchk(OFF_LVT0, LVT_RST);
      rdchk(OFF_IRR0 + 8'h08, 32'h0);
      rdchk(OFF_SVR, 32'h000000ff);
      chk(swDisabled, 1'b0);
      rdchk(OFF_ID, 32'ha7000000);
      rdchk(OFF_ARBITRATION_IDENTIFIER, 32'h5a000000);
      chk(rdB, 32'h07000000);
      restart(1'b0);
      msg(LIC_MSG_INIT, 8'h00, 1'b0);
      chk(initReq, 1'b1);
      msg(LIC_MSG_STARTUP, 8'h9a, 1'b0);
      chk(startupReq, 1'b1);
      chk(startupVector, 8'h9a);
      @(posedge sys_clk);
      #1 chk(waitStartup, 1'b0);
      // Application processor: only the bus-based variant drops stop clock
      lic_msg_model_i.pins(1'b0, 1'b0, 1'b1);
      lic_msg_model_i.pins(1'b0, 1'b0, 1'b0);
      #1 chk(stopClockReq, 1'b1);
      chk(stopClockReqB, 1'b0);
      end_sim();
   end
endmodule : test_local_intc_base_id_state
